// ==== hdl/ctu_top.sv ====
// Charge time unit control logic with APB register slave
`timescale 1ns/1ps
`include "ctu_defs.svh"
module ctu_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chip_idle,
    input wire ctu_pkg::ctu_src_t sources,
    output ctu_pkg::ctu_analog_t analog,
    output logic source_off_flag
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] high_reg, high_next; // Control high
    logic [7:0] low_reg, low_next; // Control low with status bits
    logic [7:0] icon_reg, icon_next; // Trim and range
    logic [31:0] prdata_reg, prdata_next; // Read data
    logic pslverr_reg, pslverr_next; // Error answer
    logic pready_reg, pready_next; // Answer strobe
    ctu_pkg::ctu_analog_t ana_reg, ana_next; // Analog controls
    logic flag_reg, flag_next; // Source turned off pulse
    logic src_on_prev_reg, src_on_prev_next; // Previous source enable

    // Picks the selected source level
    function automatic logic pick_source(input logic [1:0] sel, input ctu_pkg::ctu_src_t s);
        logic r;
        r = 1'b0;
        unique case (sel)
            `CTU_SRC_PIN_ONE: r = s.pin_one;
            `CTU_SRC_PIN_TWO: r = s.pin_two;
            `CTU_SRC_ENH_CMP: r = s.enh_cmp;
            `CTU_SRC_SEC_CMP: r = s.sec_cmp;
        endcase
        return r;
    endfunction : pick_source

    // True for the three register addresses; anything else answers with an error
    function automatic logic addr_mapped(input logic [11:0] a);
        return (a == `CTU_OFF_CTRL_HIGH) | (a == `CTU_OFF_CTRL_LOW)
            | (a == `CTU_OFF_CURRENT);
    endfunction : addr_mapped

    // ----------------------------------------
    // Combinational decode
    // ----------------------------------------
    logic running; // Unit active
    logic edge1_hit; // Channel one level matches
    logic edge2_hit; // Channel two level matches
    logic wr_hit; // APB write at the edge that samples pready high
    logic src_on; // Source enable term
    logic [7:0] low_view; // Registered status, without this cycle's events

    always_comb begin
        // Unit runs when on and not halted by idle
        running = high_reg[`CTU_BIT_MODULE_ON]
            & ~(high_reg[`CTU_BIT_IDLE_HALT] & chip_idle);
        // Level compare against polarity; level, not transition
        edge1_hit = running & high_reg[`CTU_BIT_EDGE_UNBLOCK]
            & (pick_source(low_reg[3:2], sources) == low_reg[`CTU_BIT_CH1_POL]);
        edge2_hit = running & high_reg[`CTU_BIT_EDGE_UNBLOCK]
            & (pick_source(low_reg[6:5], sources) == low_reg[`CTU_BIT_CH2_POL])
            & (~high_reg[`CTU_BIT_EDGE_ORDER] | low_reg[`CTU_BIT_CH1_SEEN]);
        wr_hit = psel & penable & pwrite & pready_reg;
        low_view = low_reg;
    end

    // ----------------------------------------
    // Register and bus next state
    // ----------------------------------------
    always_comb begin
        high_next = high_reg;
        low_next = low_reg;
        icon_next = icon_reg;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        pready_next = 1'b0;
        // Software write lands at the edge that samples pready high, so it
        // takes effect together with the answer; hardware set below wins
        if (wr_hit) begin
            unique case (paddr)
                `CTU_OFF_CTRL_HIGH: high_next = pwdata[7:0] & `CTU_HIGH_WMASK;
                `CTU_OFF_CTRL_LOW: low_next = pwdata[7:0];
                `CTU_OFF_CURRENT: icon_next = pwdata[7:0];
                default: icon_next = icon_reg; // Unmapped write is dropped
            endcase
        end
        // Edge responses set status bits
        if (edge1_hit) begin
            low_next[`CTU_BIT_CH1_SEEN] = 1'b1;
        end
        if (edge2_hit) begin
            low_next[`CTU_BIT_CH2_SEEN] = 1'b1;
        end
        // Access phase answered one cycle after entering it
        if (psel & penable & ~pready_reg) begin
            pready_next = 1'b1;
            // Unmapped address answers with an error in either direction
            if (!addr_mapped(paddr)) begin
                pslverr_next = 1'b1;
            end
            if (!pwrite) begin
                unique case (paddr)
                    `CTU_OFF_CTRL_HIGH: prdata_next = {24'h000000, high_reg};
                    `CTU_OFF_CTRL_LOW: prdata_next = {24'h000000, low_view};
                    `CTU_OFF_CURRENT: prdata_next = {24'h000000, icon_reg};
                    default: begin
                        prdata_next = 32'h00000000;
                        pslverr_next = 1'b1;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Analog side next state
    // ----------------------------------------
    always_comb begin
        // Exactly one status set powers the source, only when on
        src_on = (low_reg[`CTU_BIT_CH1_SEEN] ^ low_reg[`CTU_BIT_CH2_SEEN])
            & high_reg[`CTU_BIT_MODULE_ON];
        ana_next.source_enable = src_on;
        ana_next.source_ground = high_reg[`CTU_BIT_SOURCE_GROUND];
        ana_next.current_range = icon_reg[1:0];
        ana_next.current_trim_code = icon_reg[7:2];
        ana_next.delay_to_comparator = running & high_reg[`CTU_BIT_DELAY_GEN];
        // Trigger when second edge completes the measurement
        ana_next.conversion_start = running & high_reg[`CTU_BIT_CONV_TRIG]
            & low_reg[`CTU_BIT_CH1_SEEN] & low_reg[`CTU_BIT_CH2_SEEN];
        src_on_prev_next = src_on;
        flag_next = src_on_prev_reg & ~src_on;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_reg <= `CTU_RST_REG;
            low_reg <= `CTU_RST_REG;
            icon_reg <= `CTU_RST_REG;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
            pready_reg <= 1'b0;
            ana_reg <= '0;
            flag_reg <= 1'b0;
            src_on_prev_reg <= 1'b0;
        end else if (clk_en) begin
            high_reg <= high_next;
            low_reg <= low_next;
            icon_reg <= icon_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
            pready_reg <= pready_next;
            ana_reg <= ana_next;
            flag_reg <= flag_next;
            src_on_prev_reg <= src_on_prev_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign analog = ana_reg;
    assign source_off_flag = flag_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_off_quiet;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !high_reg[`CTU_BIT_MODULE_ON]) |=> !analog.source_enable
            && !analog.conversion_start;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("Source active while off");
    property p_exactly_one;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && high_reg[7] && (low_reg[0] ^ low_reg[1])) |=> analog.source_enable;
    endproperty
    a_exactly_one: assert property (p_exactly_one) else $error("Source not enabled");
    property p_flag_fall;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && $fell(analog.source_enable)) |-> source_off_flag;
    endproperty
    a_flag_fall: assert property (p_flag_fall) else $error("Missing off flag");
    property p_high_bit6;
        @(posedge pclk) disable iff (!presetn) !high_reg[6];
    endproperty
    a_high_bit6: assert property (p_high_bit6) else $error("Bit six set");
    property p_blocked;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !high_reg[3] && !wr_hit && !low_reg[0]) |=> !low_reg[0];
    endproperty
    a_blocked: assert property (p_blocked) else $error("Edge passed while blocked");
    property p_order;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && high_reg[2] && !low_reg[0] && !low_reg[1] && !wr_hit) |=> !low_reg[1];
    endproperty
    a_order: assert property (p_order) else $error("Edge two before one");
    property p_set_ch1;
        @(posedge pclk) disable iff (!presetn) (clk_en && edge1_hit) |=> low_reg[0];
    endproperty
    a_set_ch1: assert property (p_set_ch1) else $error("Status one not set");
    property p_trig;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !high_reg[0]) |=> !analog.conversion_start;
    endproperty
    a_trig: assert property (p_trig) else $error("Trigger while disabled");
    property p_answer;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && psel && penable && !pready) |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("No APB answer");
    // Bus answer checks
    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && pready) |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("Ready longer than one cycle");
    property p_err_with_ready;
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("Error without ready");
    // Control and status checks
    property p_off_no_delay;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !high_reg[`CTU_BIT_MODULE_ON]) |=> !analog.delay_to_comparator;
    endproperty
    a_off_no_delay: assert property (p_off_no_delay) else $error("Delay mode while off");
    property p_idle_stop;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && high_reg[`CTU_BIT_IDLE_HALT] && chip_idle) |=> !analog.delay_to_comparator
            && !analog.conversion_start;
    endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("Unit ran while idle");
    property p_delay_off;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !high_reg[`CTU_BIT_DELAY_GEN]) |=> !analog.delay_to_comparator;
    endproperty
    a_delay_off: assert property (p_delay_off) else $error("Delay mode while disabled");
    property p_ground;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && high_reg[`CTU_BIT_SOURCE_GROUND]) |=> analog.source_ground;
    endproperty
    a_ground: assert property (p_ground) else $error("Source not grounded");
    property p_range_off;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && icon_reg[1:0] == 2'h0) |=> analog.current_range == 2'h0;
    endproperty
    a_range_off: assert property (p_range_off) else $error("Range not disabled");
    property p_set_ch2;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && edge2_hit) |=> low_reg[`CTU_BIT_CH2_SEEN];
    endproperty
    a_set_ch2: assert property (p_set_ch2) else $error("Status two not set");
    property p_both_off;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !(low_reg[`CTU_BIT_CH1_SEEN] ^ low_reg[`CTU_BIT_CH2_SEEN]))
            |=> !analog.source_enable;
    endproperty
    a_both_off: assert property (p_both_off) else $error("Source on with equal status");
    property p_flag_pulse;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && source_off_flag) |=> !source_off_flag;
    endproperty
    a_flag_pulse: assert property (p_flag_pulse) else $error("Off flag longer than one cycle");
    c_src_on: cover property (@(posedge pclk) disable iff (!presetn) $rose(analog.source_enable));
    c_flag: cover property (@(posedge pclk) disable iff (!presetn) source_off_flag);
    c_trig: cover property (@(posedge pclk) disable iff (!presetn) analog.conversion_start);
    // Error answer and an ordered measurement waiting for its second edge
    c_read_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
    c_order_wait: cover property (@(posedge pclk) disable iff (!presetn)
        high_reg[2] && low_reg[0] && !low_reg[1]);
endmodule : ctu_top

// ==== hdl/ctu_defs.svh ====
// Register offsets, field positions, reset values and codes of the charge time unit
`ifndef CTU_DEFS_SVH
`define CTU_DEFS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define CTU_OFF_CTRL_HIGH 12'h000
`define CTU_OFF_CTRL_LOW 12'h004
`define CTU_OFF_CURRENT 12'h008
// ----------------------------------------
// Field positions in the control high register
// ----------------------------------------
`define CTU_BIT_MODULE_ON 7
`define CTU_BIT_IDLE_HALT 5
`define CTU_BIT_DELAY_GEN 4
`define CTU_BIT_EDGE_UNBLOCK 3
`define CTU_BIT_EDGE_ORDER 2
`define CTU_BIT_SOURCE_GROUND 1
`define CTU_BIT_CONV_TRIG 0
`define CTU_HIGH_WMASK 8'hBF
// ----------------------------------------
// Field positions in the control low register
// ----------------------------------------
`define CTU_BIT_CH2_POL 7
`define CTU_BIT_CH1_POL 4
`define CTU_BIT_CH2_SEEN 1
`define CTU_BIT_CH1_SEEN 0
// ----------------------------------------
// Source select codes and reset values
// ----------------------------------------
`define CTU_SRC_PIN_ONE 2'h3
`define CTU_SRC_PIN_TWO 2'h2
`define CTU_SRC_ENH_CMP 2'h1
`define CTU_SRC_SEC_CMP 2'h0
`define CTU_RST_REG 8'h00
`endif

// ==== hdl/ctu_pkg.sv ====
// Types shared by the charge time unit
package ctu_pkg;
    // Edge sources presented to the unit
    typedef struct packed {
        logic pin_one;
        logic pin_two;
        logic enh_cmp;
        logic sec_cmp;
    } ctu_src_t;
    // Outputs toward the analog current source and converter
    typedef struct packed {
        logic source_enable;
        logic source_ground;
        logic [1:0] current_range;
        logic [5:0] current_trim_code;
        logic delay_to_comparator;
        logic conversion_start;
    } ctu_analog_t;
endpackage : ctu_pkg

// ==== sim/ctu_far_side.sv ====
// Far-side model: edge source drivers and converter start counter
`timescale 1ns/1ps
module ctu_far_side (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] levels,
    output ctu_pkg::ctu_src_t sources,
    input wire ctu_pkg::ctu_analog_t analog,
    output int conv_count
);
    logic conv_q; // Trigger level seen last cycle
    // Present requested levels as synchronous lines and count conversions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sources <= '0;
            conv_q <= 1'b0;
            conv_count <= 0;
        end else begin
            sources <= ctu_pkg::ctu_src_t'(levels);
            conv_q <= analog.conversion_start;
            // One conversion per rising trigger
            if (analog.conversion_start && !conv_q) begin
                conv_count <= conv_count + 1;
            end
        end
    end
endmodule : ctu_far_side

// ==== sim/charge_time_unit_control_test.sv ====
// Self-checking bench of the charge time unit control logic
`timescale 1ns/1ps
`include "ctu_defs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("Error at %0t: got %h exp %h", $time, a, b); end end
module charge_time_unit_control_test;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic chip_idle = 1'b0;
    logic [3:0] lv = 4'h0; // Requested source levels
    logic [31:0] rd; // Last read data
    logic err; // Last error response
    logic seen; // Off flag observed
    int conv_count;
    int fail_count = 0;
    int n_tests = 0;
    ctu_pkg::ctu_src_t sources;
    ctu_pkg::ctu_analog_t analog;
    logic source_off_flag;
    logic ce = 1'b1; // Clock enable of the unit
    int conv_base; // Conversion count before the trigger test
    typedef struct packed {logic [1:0] code; logic pol; logic [3:0] src; logic exp;} ctu_row_t;
    ctu_row_t rows [8] = '{'{2'h3, 1'b1, 4'h8, 1'b1}, '{2'h2, 1'b1, 4'h4, 1'b1},
        '{2'h1, 1'b1, 4'h2, 1'b1}, '{2'h0, 1'b1, 4'h1, 1'b1}, '{2'h3, 1'b1, 4'h7, 1'b0},
        '{2'h1, 1'b0, 4'hD, 1'b1}, '{2'h2, 1'b0, 4'hF, 1'b0}, '{2'h0, 1'b0, 4'hE, 1'b1}};
    logic [5:0] trims [4] = '{6'h1F, 6'h00, 6'h3F, 6'h21};
    always #25 pclk = ~pclk;
    ctu_top ctu_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chip_idle(chip_idle), .sources(sources),
        .analog(analog), .source_off_flag(source_off_flag));
    ctu_far_side ctu_far_side_inst (.pclk(pclk), .presetn(presetn), .levels(lv),
        .sources(sources), .analog(analog), .conv_count(conv_count));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Verdict and end of run
    task end_of_test;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    // One APB transfer: setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        // Answer taken at the edge that samples pready high, then released
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Hung slave ends the run
        if (pready !== 1'b1) begin
            fail_count++;
            end_of_test();
        end
    endtask : apb
    // Let a few cycles pass; inputs then change just after a rising edge
    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `CTU_OFF_CTRL_HIGH, 0);
        `CHK(rd, 32'h0)
        apb(0, `CTU_OFF_CURRENT, 0);
        `CHK(rd, 32'h0)
        apb(1, `CTU_OFF_CTRL_HIGH, 32'hFF);
        apb(0, `CTU_OFF_CTRL_HIGH, 0);
        `CHK(rd, 32'hBF)
        apb(0, 12'h00C, 0);
        `CHK({err, rd}, 33'h100000000)
        apb(1, 12'h00C, 32'h5);
        `CHK(err, 1'b1)
        // Source select and polarity table
        foreach (rows[k]) begin
            apb(1, `CTU_OFF_CTRL_HIGH, 32'h80);
            apb(1, `CTU_OFF_CTRL_LOW, {27'h0, rows[k].pol, rows[k].code, 2'h0});
            lv <= rows[k].src;
            apb(1, `CTU_OFF_CTRL_HIGH, 32'h88);
            apb(0, `CTU_OFF_CTRL_LOW, 0);
            `CHK(rd[0], rows[k].exp)
        end
        // Blocking, then order, then set by level
        apb(1, `CTU_OFF_CTRL_HIGH, 32'h84);
        apb(1, `CTU_OFF_CTRL_LOW, 32'hDC);
        lv <= 4'hC;
        apb(0, `CTU_OFF_CTRL_LOW, 0);
        `CHK(rd, 32'hDC)
        lv <= 4'h4;
        apb(1, `CTU_OFF_CTRL_HIGH, 32'h8C);
        apb(0, `CTU_OFF_CTRL_LOW, 0);
        `CHK(rd, 32'hDC)
        lv <= 4'hC;
        wt(3);
        apb(0, `CTU_OFF_CTRL_LOW, 0);
        `CHK(rd, 32'hDF)
        // Source window by software status
        apb(1, `CTU_OFF_CTRL_HIGH, 32'h80);
        apb(1, `CTU_OFF_CTRL_LOW, 32'h01);
        wt(3);
        `CHK(analog.source_enable, 1'b1)
        apb(1, `CTU_OFF_CTRL_LOW, 32'h03);
        seen = 1'b0;
        repeat (6) begin
            @(posedge pclk);
            seen = seen | (source_off_flag === 1'b1);
        end
        `CHK(seen, 1'b1)
        `CHK(analog.source_enable, 1'b0)
        conv_base = conv_count;
        apb(1, `CTU_OFF_CTRL_HIGH, 32'h81);
        wt(3);
        `CHK(analog.conversion_start, 1'b1)
        `CHK(conv_count, conv_base + 1)
        apb(1, `CTU_OFF_CTRL_HIGH, 32'h80);
        wt(3);
        `CHK(analog.conversion_start, 1'b0)
        `CHK(analog.source_ground, 1'b0)
        apb(1, `CTU_OFF_CTRL_LOW, 32'h01);
        apb(1, `CTU_OFF_CTRL_HIGH, 32'h02);
        wt(3);
        `CHK(analog.source_enable, 1'b0)
        apb(1, `CTU_OFF_CTRL_HIGH, 32'h82);
        wt(3);
        `CHK(analog.source_ground, 1'b1)
        // Delay mode, halted while idle
        apb(1, `CTU_OFF_CTRL_HIGH, 32'hB0);
        chip_idle <= 1'b1;
        wt(3);
        `CHK(analog.delay_to_comparator, 1'b0)
        chip_idle <= 1'b0;
        wt(3);
        `CHK(analog.delay_to_comparator, 1'b1)
        // Every range code with trim extremes
        for (int k = 0; k < 4; k++) begin
            apb(1, `CTU_OFF_CURRENT, {24'h0, trims[k], 2'(k)});
            wt(2);
            `CHK({analog.current_trim_code, analog.current_range}, {trims[k], 2'(k)})
        end
        // Order holds channel two back; clock enable low freezes status
        apb(1, `CTU_OFF_CTRL_HIGH, 32'h80);
        lv <= 4'h0;
        apb(1, `CTU_OFF_CTRL_LOW, 32'h10);
        apb(1, `CTU_OFF_CTRL_HIGH, 32'h8C);
        wt(3);
        `CHK(analog.source_enable, 1'b0)
        ce <= 1'b0;
        lv <= 4'h1;
        wt(4);
        `CHK(analog.source_enable, 1'b0)
        ce <= 1'b1;
        wt(3);
        `CHK(analog.source_enable, 1'b1)
        // Reset in mid-run clears everything, then the bus works again
        presetn <= 1'b0;
        wt(2);
        `CHK(analog, 12'h000)
        presetn <= 1'b1;
        apb(0, `CTU_OFF_CTRL_LOW, 0);
        `CHK(rd, 32'h0)
        end_of_test();
    end
endmodule : charge_time_unit_control_test
